/* hdl/dbu_pkg.sv */
// Constants, lookup tables and carrier types of the DES block cipher unit
package dbu_pkg;
  // ---------------------------------------------------------------
  // Register indices on the 12-bit host address
  // ---------------------------------------------------------------
  localparam logic [11:0] A_CTRL   = 12'h200;
  localparam logic [11:0] A_STAT   = 12'h201;
  localparam logic [11:0] A_KEY0   = 12'h202;
  localparam logic [11:0] A_IV_LO  = 12'h208;
  localparam logic [11:0] A_IV_HI  = 12'h209;
  localparam logic [11:0] A_DIN_LO = 12'h20a;
  localparam logic [11:0] A_DIN_HI = 12'h20b;
  localparam logic [11:0] A_DOUT_LO = 12'h20c;
  localparam logic [11:0] A_DOUT_HI = 12'h20d;
  localparam logic [11:0] A_CFG    = 12'h20e;
  localparam int          KEY_WORDS = 6;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          B_CHAIN   = 29;
  localparam int          B_TRIPLE  = 30;
  localparam int          B_ENCRYPT = 31;
  localparam int          B_SRST    = 30;
  localparam int          B_MASK      = 31;
  localparam int          B_IN_SPACE  = 30;
  localparam int          B_OUT_AVAIL = 31;
  localparam logic        MASK_RST    = 1'b1;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Round and pass counts, and the rounds that shift by one place
  // ---------------------------------------------------------------
  localparam logic [3:0]  LAST_ROUND  = 4'hf;
  localparam logic [1:0]  LAST_TRIPLE = 2'h2;
  localparam logic [15:0] SHIFT_ONE   = 16'h8103;

  // ---------------------------------------------------------------
  // Permutation tables, one byte per entry, 1-based, and S-boxes, one nibble per entry; first entry on top
  // ---------------------------------------------------------------
  localparam logic [447:0] PC1_TAB = {
    64'h3931292119110901, 64'h3a322a221a120a02, 64'h3b332b231b130b03, 32'h3c342c24,
    64'h3f372f271f170f07, 64'h3e362e261e160e06, 64'h3d352d251d150d05, 32'h1c140c04};
  localparam logic [383:0] PC2_TAB = {
    64'h0e110b180105031c, 64'h0f06150a17130c04, 64'h1a0810071b140d02,
    64'h29341f252f371e28, 64'h332d21302c312738, 64'h22352e2a32241d20};
  localparam logic [255:0] P_TAB   = {
    64'h100714151d0c1c11, 64'h010f171a05121f0a, 64'h0208180e201b0309, 64'h130d1e06160b0419};
  localparam logic [255:0] SBOX [8] = '{
    256'he4d12fb83a6c59070f74e2d1a6cb953841e8d62bfc973a50fc8249175b3ea06d,
    256'hf18e6b34972dc05a3d47f28ec01a69b50e7ba4d158c6932fd8a13f42b67c05e9,
    256'ha09e63f51dc7b428d709346a285ecbf1d6498f30b12c5ae71ad069874fe3b52c,
    256'h7de3069a1285bc4fd8b56f03472c1ae9a690cb7df13e52843f06a1d8945bc72e,
    256'h2c417ab6853fd0e9eb2c47d150fa3986421bad78f9c5630eb8c71e2d6f09a453,
    256'hc1af92680d34e75baf427c9561de0b389ef528c3704a1db6432c95fabe17608d,
    256'h4b2ef08d3c975a61d0b7491ae35c2f8614bdc37eaf6805926bd814a7950fe23c,
    256'hd2846fb1a93e50c71fd8a374c56b0e927b419ce206adf35821e74a8dfc90356b};

  // ---------------------------------------------------------------
  // Host request carrier and engine states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dbu_req_t;

  typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} dbu_eng_t;
endpackage

/* hdl/dbu_top.sv */
// DES block cipher unit: host registers, block buffering and iterative round engine
// What this block does
// (R1) Software reset bit 30 of config resets like hardware, then clears itself.
// (R2) Config bit 31 masks the interrupt pin; set by every reset.
// (R3) Config bits 0 to 29 read as zero.
// (R4) Status bit 30 high while another input block can be accepted.
// (R5) Status bit 31 high while a result waits in the output words.
// (R6) Finished block raises the output flag and, unmasked, the low interrupt pin.
// (R7) Unmasked interrupt pin follows the output flag exactly, no clear action.
// (R8) Next result waits in a working register until output is read.
// (R9) Three keys of two words; parity bits are dropped by the transform.
// (R10) Single mode uses only the first key; triple mode uses all three.
// (R11) Host writes third key equal to first for two-key triple operation.
// (R12) Host loads keys first, second, third for three-key operation.
// (R13) Host never writes keys while a block is processed.
// (R14) Host loads the chaining vector first and never during processing.
// (R15) Chaining vector advances per block and stays readable.
// (R16) Low input word first; writing the high word starts processing.
// (R17) Low output word read first; high word read consumes the block.
// (R18) With two unread results the engine stalls instead of overwriting.
// (R19) Input flag drops after three unread blocks; more writes overwrite the pending third block.
// (R20) Control bits: 29 chaining, 30 triple, 31 encrypt.
// (R21) Standard DES rounds; triple is E-D-E encrypting, inverse when decrypting.
// (R22) Chaining xors the vector before encrypting, after decrypting.
`timescale 1ns/1ps
module dbu_top import dbu_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire dbu_req_t    host_req,
  output logic [31:0]      host_rdata,
  output logic             irq_n
);

  // ---------------------------------------------------------------
  // Transform helpers
  // ---------------------------------------------------------------
  // Initial permutation source bit, 1-based, for output position o
  function automatic int ip_src(input int o);
    return ((o / 8) < 4 ? 58 + 2 * (o / 8) : 49 + 2 * (o / 8)) - 8 * (o % 8);
  endfunction
  function automatic logic [63:0] ip_fn(input logic [63:0] x);
    for (int o = 0; o < 64; o++) ip_fn[63-o] = x[64-ip_src(o)];
  endfunction
  function automatic logic [63:0] fp_fn(input logic [63:0] x);
    for (int o = 0; o < 64; o++) fp_fn[64-ip_src(o)] = x[63-o];
  endfunction

  // Key bits 8, 16 .. 64 are parity and never picked here
  function automatic logic [55:0] pc1_fn(input logic [63:0] k);
    for (int j = 0; j < 56; j++) pc1_fn[55-j] = k[64-int'(PC1_TAB[447-8*j -: 8])]; // [R9]
  endfunction
  function automatic logic [47:0] pc2_fn(input logic [55:0] cd);
    for (int j = 0; j < 48; j++) pc2_fn[47-j] = cd[56-int'(PC2_TAB[383-8*j -: 8])];
  endfunction
  // Round function: expand, mix key, substitute, permute
  function automatic logic [31:0] f_fn(input logic [31:0] r, input logic [47:0] k);
    logic [47:0] x;
    logic [31:0] s;
    logic [5:0]  b;
    x = '0;
    s = '0;
    for (int j = 0; j < 48; j++) x[47-j] = r[31-((4*(j/6)+(j%6)+31)%32)];
    x = x ^ k;
    for (int g = 0; g < 8; g++) begin
      b = x[47-6*g -: 6];
      s[31-4*g -: 4] = SBOX[g][255-4*int'({b[5], b[0], b[4:1]}) -: 4];
    end
    for (int j = 0; j < 32; j++) f_fn[31-j] = s[32-int'(P_TAB[255-8*j -: 8])];
  endfunction

  // Rotate both 28-bit key halves by one or two places
  function automatic logic [55:0] rot_fn(input logic [55:0] cd, input logic left, input logic one);
    logic [27:0] c;
    logic [27:0] d;
    c = cd[55:28];
    d = cd[27:0];
    if (left && one) begin
      rot_fn = {c[26:0], c[27], d[26:0], d[27]};
    end else if (left) begin
      rot_fn = {c[25:0], c[27:26], d[25:0], d[27:26]};
    end else if (one) begin
      rot_fn = {c[0], c[27:1], d[0], d[27:1]};
    end else begin
      rot_fn = {c[1:0], c[27:2], d[1:0], d[27:2]};
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        srst_q;
  logic        mask_q;
  logic [2:0]  ctrl_q;
  logic [31:0] key_q [KEY_WORDS];
  logic [63:0] iv_q;
  logic [63:0] din_q;
  logic        in_full_q;
  dbu_eng_t    eng_q;
  logic [3:0]  round_q;
  logic [1:0]  pass_q;
  logic [31:0] l_q;
  logic [31:0] r_q;
  logic [55:0] cd_q;
  logic [63:0] blk_q;
  logic [63:0] hold_q;
  logic        hold_full_q;
  logic [63:0] dout_q;
  logic        out_full_q;
  logic [31:0] rdata_q;
  logic        irq_n_q;

  // ---------------------------------------------------------------
  // Host decode
  // ---------------------------------------------------------------
  wire rst_int   = !resetn || srst_q;                           // [R1]
  wire wr_ctrl   = host_req.wr && host_req.addr == A_CTRL;
  wire wr_cfg    = host_req.wr && host_req.addr == A_CFG;
  wire wr_iv_lo  = host_req.wr && host_req.addr == A_IV_LO;
  wire wr_iv_hi  = host_req.wr && host_req.addr == A_IV_HI;
  wire wr_din_lo = host_req.wr && host_req.addr == A_DIN_LO;
  wire wr_din_hi = host_req.wr && host_req.addr == A_DIN_HI;
  wire consume   = host_req.rd && host_req.addr == A_DOUT_HI;   // [R17]
  wire key_hit   = host_req.addr >= A_KEY0 && host_req.addr < A_IV_LO;
  wire [2:0] key_idx = host_req.addr[2:0] - A_KEY0[2:0];

  // Mode bits
  wire cbc     = ctrl_q[0];
  wire triple  = ctrl_q[1];
  wire encrypt = ctrl_q[2];

  // ---------------------------------------------------------------
  // Engine datapath
  // ---------------------------------------------------------------
  // Encrypting order K1 K2 K3, decrypting K3 K2 K1; single uses K1
  wire        start     = eng_q == ENG_IDLE && in_full_q && !hold_full_q; // [R18]
  wire [1:0]  pass_nx   = start ? 2'h0 : pass_q + 2'h1;
  wire [1:0]  kpass     = triple ? (encrypt ? pass_nx : LAST_TRIPLE - pass_nx) : 2'h0; // [R10] [R21]
  wire [63:0] key_sel   = {key_q[2*kpass+1], key_q[2*kpass]};
  wire [55:0] cd_load   = pc1_fn(key_sel);
  wire        pass_dec  = encrypt ? (pass_q == 2'h1) : (pass_q != 2'h1); // [R21]
  wire        one_now   = SHIFT_ONE[round_q];
  wire        one_back  = SHIFT_ONE[LAST_ROUND - round_q];
  wire [55:0] cd_use    = pass_dec ? cd_q : rot_fn(cd_q, 1'b1, one_now);
  wire [55:0] cd_next   = pass_dec ? rot_fn(cd_q, 1'b0, one_back) : cd_use;
  wire [31:0] r_new     = l_q ^ f_fn(r_q, pc2_fn(cd_use));
  wire        pass_end  = eng_q == ENG_RUN && round_q == LAST_ROUND;
  wire        last_pass = !triple || pass_q == LAST_TRIPLE;
  wire        fin       = pass_end && last_pass;
  wire [63:0] din_mix   = din_q ^ ((cbc && encrypt) ? iv_q : 64'h0); // [R22]
  wire [63:0] result    = fp_fn({r_new, r_q}) ^ ((cbc && !encrypt) ? iv_q : 64'h0); // [R22]

  // Output and hold steering
  wire to_out   = fin && !out_full_q;
  wire to_hold  = fin && out_full_q;                            // [R8]
  wire move     = !fin && !out_full_q && hold_full_q;           // [R8]
  wire out_full_d = (to_out || move) ? 1'b1 : (consume ? 1'b0 : out_full_q);
  wire mask_d   = wr_cfg ? host_req.wdata[B_MASK] : mask_q;

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  wire [31:0] rd_ctrl = {ctrl_q, 29'h0};                         // [R20]
  wire [31:0] rd_cfg  = {mask_q, srst_q, 30'h0};                 // [R3]
  wire [31:0] rd_stat = {out_full_q, !in_full_q, 30'h0};         // [R4] [R5] [R19]
  wire [31:0] rd_mux  =
      host_req.addr == A_CTRL    ? rd_ctrl :
      host_req.addr == A_CFG     ? rd_cfg :
      host_req.addr == A_STAT    ? rd_stat :
      key_hit                    ? key_q[key_idx] :
      host_req.addr == A_IV_LO   ? iv_q[31:0] :                  // [R15]
      host_req.addr == A_IV_HI   ? iv_q[63:32] :
      host_req.addr == A_DIN_LO  ? din_q[31:0] :
      host_req.addr == A_DIN_HI  ? din_q[63:32] :
      host_req.addr == A_DOUT_LO ? dout_q[31:0] :
      host_req.addr == A_DOUT_HI ? dout_q[63:32] : WORD_ZERO;

  // ---------------------------------------------------------------
  // Configuration and control registers
  // ---------------------------------------------------------------
  // Software reset pulse lasts one cycle and clears itself; only the pin resets this register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_cfg && host_req.wdata[B_SRST] && !srst_q;    // [R1]
    end
  end

  // Mask and mode bits
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      mask_q <= MASK_RST;                                        // [R2]
      ctrl_q <= 3'h0;
    end else begin
      mask_q <= mask_d;
      if (wr_ctrl) ctrl_q <= host_req.wdata[B_ENCRYPT -: 3];     // [R20]
    end
  end

  // Key words, one register per word
  for (genvar k = 0; k < KEY_WORDS; k++) begin : g_key
    always_ff @(posedge sys_clk) begin
      if (rst_int) begin
        key_q[k] <= WORD_ZERO;
      end else if (host_req.wr && key_hit && key_idx == k) begin // [R9]
        key_q[k] <= host_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input word and chaining vector
  // ---------------------------------------------------------------
  // A new high-word write keeps the block pending even as the engine takes one
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      din_q     <= 64'h0;
      in_full_q <= 1'b0;
      iv_q      <= 64'h0;
    end else begin
      if (wr_din_lo) din_q[31:0] <= host_req.wdata;
      if (wr_din_hi) din_q[63:32] <= host_req.wdata;
      in_full_q <= wr_din_hi || (in_full_q && !start);           // [R16] [R19]
      if (fin && cbc) begin
        iv_q <= encrypt ? result : blk_q;                        // [R15]
      end else begin
        if (wr_iv_lo) iv_q[31:0] <= host_req.wdata;
        if (wr_iv_hi) iv_q[63:32] <= host_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Round engine
  // ---------------------------------------------------------------
  // One round per clock; passes hand over swapped halves, so IP and FP cancel
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      eng_q   <= ENG_IDLE;
      round_q <= 4'h0;
      pass_q  <= 2'h0;
      l_q     <= WORD_ZERO;
      r_q     <= WORD_ZERO;
      cd_q    <= 56'h0;
      blk_q   <= 64'h0;
    end else if (start) begin
      eng_q      <= ENG_RUN;                                     // [R16]
      round_q    <= 4'h0;
      pass_q     <= 2'h0;
      {l_q, r_q} <= ip_fn(din_mix);                              // [R21]
      cd_q       <= cd_load;
      blk_q      <= din_q;
    end else if (eng_q == ENG_RUN) begin
      round_q <= round_q + 4'h1;
      if (fin) begin
        eng_q <= ENG_IDLE;
      end else if (pass_end) begin
        pass_q <= pass_nx;
        l_q    <= r_new;
        r_q    <= r_q;
        cd_q   <= cd_load;
      end else begin
        l_q  <= r_q;
        r_q  <= r_new;
        cd_q <= cd_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output words, working register and host outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      dout_q      <= 64'h0;
      out_full_q  <= 1'b0;
      hold_q      <= 64'h0;
      hold_full_q <= 1'b0;
      rdata_q     <= WORD_ZERO;
      irq_n_q     <= 1'b1;
    end else begin
      if (to_out) dout_q <= result;                              // [R6]
      if (move) dout_q <= hold_q;                                // [R8]
      if (to_hold) hold_q <= result;
      hold_full_q <= to_hold || (hold_full_q && !move);
      out_full_q  <= out_full_d;                                 // [R5] [R17]
      if (host_req.rd) rdata_q <= rd_mux;
      irq_n_q     <= !(out_full_d && !mask_d);                   // [R6] [R7]
    end
  end

  assign host_rdata = rdata_q;
  assign irq_n      = irq_n_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_srst_clear;
    @(posedge sys_clk) disable iff (!resetn) srst_q |=> !srst_q && mask_q && !out_full_q;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not act or clear"); // [R1]
  property p_mask_reset;
    @(posedge sys_clk) disable iff (!resetn) $rose(srst_q) |=> irq_n && mask_q;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not set by soft reset"); // [R2]
  property p_cfg_zero;
    @(posedge sys_clk) disable iff (rst_int) host_req.rd && host_req.addr == A_CFG |=> rdata_q[29:0] == 30'h0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("config unused bits not zero"); // [R3]
  property p_in_space;
    @(posedge sys_clk) disable iff (rst_int)
      host_req.rd && host_req.addr == A_STAT |=>
        rdata_q[B_IN_SPACE] == !$past(in_full_q) && rdata_q[B_OUT_AVAIL] == $past(out_full_q);
  endproperty
  a_in_space: assert property (p_in_space) else $error("status flags wrong"); // [R4] [R5]
  property p_irq_follow;
    @(posedge sys_clk) disable iff (rst_int) irq_n == !(out_full_q && !mask_q);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt pin not following flag"); // [R7]
  property p_start;
    @(posedge sys_clk) disable iff (rst_int)
      wr_din_hi && eng_q == ENG_IDLE && !in_full_q && !hold_full_q |=> ##1 eng_q == ENG_RUN;
  endproperty
  a_start: assert property (p_start) else $error("high input write did not start engine"); // [R16]
  property p_consume;
    @(posedge sys_clk) disable iff (rst_int) consume && out_full_q && !hold_full_q |=> !out_full_q;
  endproperty
  a_consume: assert property (p_consume) else $error("high output read did not consume"); // [R17]
  property p_stall;
    @(posedge sys_clk) disable iff (rst_int) hold_full_q && eng_q == ENG_IDLE |=> eng_q == ENG_IDLE;
  endproperty
  a_stall: assert property (p_stall) else $error("engine ran over unread results"); // [R18]
  property p_move;
    @(posedge sys_clk) disable iff (rst_int) !out_full_q && hold_full_q |=> out_full_q && !hold_full_q;
  endproperty
  a_move: assert property (p_move) else $error("held result not copied out"); // [R8]
endmodule

/* sim/dbu_host_model.sv */
// Host processor model driving register accesses of the cipher unit
`timescale 1ns/1ps
module dbu_host_model import dbu_pkg::*; (
  input  wire logic        sys_clk,
  output dbu_req_t         host_req,
  input  wire logic [31:0] host_rdata
);
  // ---------------------------------------------------------------
  // Word accesses
  // ---------------------------------------------------------------
  initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 12'h000, wdata: 32'h0000_0000};

  // One write; released lines show the inverse of the last value
  task automatic wr_word(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read; data is taken once the answering edge has settled
  task automatic rd_word(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: host_req.wdata};
    @(posedge sys_clk);
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~host_req.wdata};
    @(negedge sys_clk);
    d = host_rdata;
  endtask

  // ---------------------------------------------------------------
  // Block transfers and context loading
  // ---------------------------------------------------------------
  // Low input word first; the high word starts processing
  task automatic wr_block(input logic [63:0] b);
    wr_word(A_DIN_LO, b[31:0]);
    wr_word(A_DIN_HI, b[63:32]);
  endtask

  // Low output word first; the high word frees the output
  task automatic rd_block(output logic [63:0] b);
    rd_word(A_DOUT_LO, b[31:0]);
    rd_word(A_DOUT_HI, b[63:32]);
  endtask

  // Mode, vector, keys in order first to third, only while idle
  task automatic set_ctx(input logic [31:0] mode, input logic [63:0] iv, k1, k2, k3);
    logic [63:0] k [3];
    k = '{k1, k2, k3};
    wr_word(A_CTRL, mode);
    wr_word(A_IV_LO, iv[31:0]);
    wr_word(A_IV_HI, iv[63:32]);
    for (int i = 0; i < 3; i++) begin
      wr_word(A_KEY0 + 12'(2 * i), k[i][31:0]);
      wr_word(A_KEY0 + 12'(2 * i + 1), k[i][63:32]);
    end
  endtask
endmodule

/* sim/dbu_top_test.sv */
// Self-checking testbench of the DES block cipher unit
`timescale 1ns/1ps
module dbu_top_test import dbu_pkg::*; ;
  // ---------------------------------------------------------------
  // Known vectors and control words
  // ---------------------------------------------------------------
  localparam logic [63:0] K_A = 64'h1334_5779_9bbc_dff1;
  localparam logic [63:0] K_B = 64'h0e32_9232_ea6d_0d73;
  localparam logic [63:0] P_A = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] C_A = 64'h85e8_1354_0f0a_b405;
  localparam logic [63:0] P_B = 64'h8787_8787_8787_8787;
  localparam logic [63:0] P_2 = 64'h84cb_5633_86a1_79ea;
  localparam logic [63:0] PAR = 64'h0101_0101_0101_0101;
  localparam logic [63:0] Z64 = 64'h0;
  localparam logic [31:0] W31 = 32'h8000_0000;
  localparam logic [31:0] W30 = 32'h4000_0000;
  localparam logic [31:0] W29 = 32'h2000_0000;

  logic        sys_clk;
  logic        resetn;
  dbu_req_t    host_req;
  logic [31:0] host_rdata;
  logic        irq_n;
  int          fail_count;
  int          comparisons;

  dbu_top i_dut (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .host_req   (host_req),
    .host_rdata (host_rdata),
    .irq_n      (irq_n)
  );

  dbu_host_model i_host (
    .sys_clk    (sys_clk),
    .host_req   (host_req),
    .host_rdata (host_rdata)
  );

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    i_host.rd_word(a, v);
    check(what, {32'h0, v}, {32'h0, exp});
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Poll the status word until a result waits, bounded
  task automatic wait_out();
    logic [31:0] s;
    for (int n = 0; n < 40; n++) begin
      i_host.rd_word(A_STAT, s);
      if (s[B_OUT_AVAIL] === 1'b1) return;
    end
    check("output flag", 64'h0, 64'h1);
    report_and_stop();
  endtask

  // One block in, one result out and compared
  task automatic run(input logic [63:0] p, input logic [63:0] exp, input string what);
    logic [63:0] got;
    i_host.wr_block(p);
    wait_out();
    i_host.rd_block(got);
    check(what, got, exp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk(A_CFG, W31, "config after reset");
    rd_chk(A_STAT, W30, "status after reset");
    rd_chk(12'h210, 32'h0, "unmapped read");
    check("irq idle", {63'h0, irq_n}, 64'h1);
    $display("test reset done");
  endtask

  task automatic t_single();
    logic [63:0] got;
    i_host.set_ctx(W31, Z64, K_A, K_B, K_B);
    i_host.wr_block(P_A);
    wait_out();
    rd_chk(A_STAT, W31 | W30, "status result waiting");
    check("masked irq", {63'h0, irq_n}, 64'h1);
    i_host.rd_block(got);
    check("single encrypt", got, C_A);
    rd_chk(A_STAT, W30, "status consumed");
    i_host.set_ctx(32'h0, Z64, K_A ^ PAR, K_B, K_B);
    run(C_A, P_A, "single decrypt parity flipped");
    $display("test single done");
  endtask

  task automatic t_triple();
    i_host.set_ctx(W31 | W30, Z64, K_B, K_B, K_A);
    run(P_A, C_A, "triple encrypt third key");
    i_host.set_ctx(W31 | W30, Z64, K_B, K_A, K_A);
    run(P_B, Z64, "triple encrypt first key");
    i_host.set_ctx(W30, Z64, K_B, K_B, K_A);
    run(C_A, P_A, "triple decrypt");
    i_host.set_ctx(W31 | W30, Z64, K_A, K_A, K_A);
    run(P_A, C_A, "triple third equals first");
    $display("test triple done");
  endtask

  task automatic t_chain();
    i_host.set_ctx(W31 | W29, Z64, K_A, K_B, K_B);
    run(P_A, C_A, "chain first block");
    run(P_2, C_A, "chain second block");
    rd_chk(A_IV_LO, C_A[31:0], "vector low");
    rd_chk(A_IV_HI, C_A[63:32], "vector high");
    i_host.set_ctx(W29, Z64, K_A, K_B, K_B);
    run(C_A, P_A, "chain decrypt first");
    run(C_A, P_2, "chain decrypt second");
    $display("test chain done");
  endtask

  task automatic t_irq();
    logic [31:0] w;
    i_host.wr_word(A_CFG, 32'h0);
    rd_chk(A_CFG, 32'h0, "config unmasked");
    i_host.set_ctx(W31, Z64, K_A, K_B, K_B);
    check("irq before result", {63'h0, irq_n}, 64'h1);
    i_host.wr_block(P_A);
    wait_out();
    check("irq on result", {63'h0, irq_n}, 64'h0);
    i_host.rd_word(A_DOUT_LO, w);
    check("irq after low read", {63'h0, irq_n}, 64'h0);
    i_host.rd_word(A_DOUT_HI, w);
    check("irq after high read", {63'h0, irq_n}, 64'h1);
    $display("test interrupt done");
  endtask

  task automatic t_srst();
    i_host.wr_word(A_CFG, W30);
    repeat (2) @(posedge sys_clk);
    rd_chk(A_CFG, W31, "config after soft reset");
    rd_chk(A_KEY0, 32'h0, "key after soft reset");
    rd_chk(A_CTRL, 32'h0, "control after soft reset");
    $display("test soft reset done");
  endtask

  task automatic t_stall();
    logic [63:0] got;
    i_host.set_ctx(W31, Z64, K_A, K_B, K_B);
    i_host.wr_block(P_A);
    wait_out();
    i_host.wr_block(P_A);
    repeat (60) @(posedge sys_clk);
    i_host.wr_block(P_A);
    rd_chk(A_STAT, W31, "status three unread");
    for (int i = 0; i < 3; i++) begin
      wait_out();
      i_host.rd_block(got);
      check("buffered result", got, C_A);
    end
    rd_chk(A_STAT, W30, "status drained");
    $display("test stall done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    fail_count = 0;
    comparisons = 0;
    resetn = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_single();
    t_triple();
    t_chain();
    t_irq();
    t_srst();
    t_stall();
    report_and_stop();
  end
endmodule
